/* hw/vicwt_pkg.sv */
// Constants, types and register map of the vectored interrupt controller
package vicwt_pkg;
  // Sizes
  localparam int NUM_SRC = 16;
  localparam int NUM_EXT = 5;
  localparam int NUM_PER = NUM_SRC - NUM_EXT;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int VEC_W = 24;
  localparam int PRIO_PER_REG = 4;
  localparam int PRIO_STRIDE = 4;
  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PRIO0 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PRIO3 = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_CORE = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 4'h9;
  // Field positions
  localparam int STAT_IPL_LSB = 5;
  localparam int CORE_MSB_BIT = 3;
  localparam int CTRL1_NEST_BIT = 15;
  localparam logic [DATA_W-1:0] STAT_PLAIN_MASK = 16'h010f;
  // Reset values and levels
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [NUM_SRC-1:0] FLAG_RESET = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_ZERO = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
  localparam logic [NUM_EXT-1:0] POL_RESET = 5'h00;
  // Vector table layout in program memory
  localparam logic [VEC_W-1:0] VEC_BASE = 24'h000014;
  localparam logic [VEC_W-1:0] VEC_STRIDE = 24'h000002;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SAVE = 3'b001,
    ST_VEC = 3'b010,
    ST_LOAD = 3'b011,
    ST_POP_HI = 3'b100,
    ST_POP_LO = 3'b101,
    ST_REFETCH = 3'b110
  } vicwt_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } vicwt_bus_t;

  typedef struct packed {
    logic [7:0] status_low;
    logic prio_msb;
  } vicwt_ctx_t;
endpackage

/* hw/vicwt_ctrl.sv */
// Interrupt controller: flags, priorities, wake, entry and return sequencing
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vicwt_ctrl
  import vicwt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire vicwt_bus_t bus_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic [NUM_EXT-1:0] ext_pin_in,
  input wire logic [NUM_PER-1:0] periph_evt_in,
  input wire logic sleep_in,
  input wire logic ret_instr_in,
  input wire vicwt_ctx_t pop_ctx_in,
  output logic wake_out,
  output logic resume_out,
  output logic int_req_out,
  output logic ctx_save_out,
  output vicwt_ctx_t ctx_out,
  output logic vec_fetch_out,
  output logic [VEC_W-1:0] vec_addr_out,
  output logic isr_load_out,
  output logic nop_exec_out,
  output logic pop_hi_out,
  output logic pop_lo_out,
  output logic ret_fetch_out,
  output logic adc_trigger_out
);
  vicwt_state_t state_r;
  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] enable_r;
  logic [PRIO_W-1:0] prio_r [NUM_SRC];
  logic [DATA_W-1:0] status_r;
  logic core_msb_r;
  logic nest_dis_r;
  logic [NUM_EXT-1:0] pol_r;
  logic [NUM_EXT-1:0] sync1_r;
  logic [NUM_EXT-1:0] sync2_r;
  logic [NUM_EXT-1:0] prev_r;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] wake_src;
  logic [PRIO_W-1:0] best_prio;
  logic [IDX_W-1:0] best_idx;
  logic [PRIO_W-1:0] sel_prio_r;
  logic [IDX_W-1:0] sel_idx_r;
  logic [LEVEL_W-1:0] cpu_level;
  logic [PRIO_W-1:0] ipl_low;
  logic any_wake;
  logic req_hit;
  logic start_entry;
  logic start_ret;
  logic [DATA_W-1:0] rd_mux;
  logic flag_we;
  logic stat_we;
  logic core_we;

  // Bus write decode
  assign flag_we = bus_in.wr && (bus_in.addr == ADDR_FLAG);
  assign stat_we = bus_in.wr && (bus_in.addr == ADDR_STATUS);
  assign core_we = bus_in.wr && (bus_in.addr == ADDR_CORE);

  // Level composed from top bit and status bits
  assign ipl_low = status_r[STAT_IPL_LSB +: PRIO_W];
  assign cpu_level = {core_msb_r, ipl_low};

  // Pin synchroniser and edge detector, one per external pin
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= ext_pin_in[g];
          sync2_r[g] <= sync1_r[g];
          prev_r[g] <= sync2_r[g];
        end
      end
      // Polarity set selects falling edge
      assign ext_edge[g] = pol_r[g] ? (prev_r[g] & ~sync2_r[g]) :
                                      (~prev_r[g] & sync2_r[g]);
    end
  endgenerate

  // Natural order: pins take vectors 0..4, peripherals follow
  assign set_vec = {periph_evt_in, ext_edge};

  // Converter trigger shares pin zero detector and its polarity
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      adc_trigger_out <= 1'b0;
    end else begin
      adc_trigger_out <= ext_edge[0];
    end
  end

  // Sticky flags; an event beats a same-cycle software clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_r <= FLAG_RESET;
    end else begin
      flags_r <= (flag_we ? bus_in.wdata : flags_r) | set_vec;
    end
  end

  // Enable register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      enable_r <= FLAG_RESET;
    end else if (bus_in.wr && (bus_in.addr == ADDR_ENABLE)) begin
      enable_r <= bus_in.wdata;
    end
  end

  // Priority fields, four sources to a register word
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_prio
      localparam logic [ADDR_W-1:0] REG_IDX =
        ADDR_PRIO0 + ADDR_W'(g / PRIO_PER_REG);
      localparam int FLD_LSB = (g % PRIO_PER_REG) * PRIO_STRIDE;
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          prio_r[g] <= PRIO_ZERO;
        end else if (bus_in.wr && (bus_in.addr == REG_IDX)) begin
          prio_r[g] <= bus_in.wdata[FLD_LSB +: PRIO_W];
        end
      end
      assign pend[g] = flags_r[g] & enable_r[g];
      // Priority zero means disabled, even for wake
      assign wake_src[g] = pend[g] & (prio_r[g] != PRIO_ZERO);
    end
  endgenerate

  assign any_wake = |wake_src;

  // Highest priority wins; scanning downward makes ties go low
  always_comb begin
    best_prio = PRIO_ZERO;
    best_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (wake_src[i] && (prio_r[i] >= best_prio)) begin
        best_prio = prio_r[i];
        best_idx = IDX_W'(i);
      end
    end
  end

  // Strictly above level; level 7 or more blocks all user sources
  assign req_hit = any_wake &&
    ({1'b0, best_prio} > cpu_level);
  assign start_entry = (state_r == ST_IDLE) && req_hit;
  assign start_ret = (state_r == ST_IDLE) && !req_hit && ret_instr_in;

  // Control registers: nesting disable and pin polarities
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nest_dis_r <= 1'b0;
      pol_r <= POL_RESET;
    end else begin
      if (bus_in.wr && (bus_in.addr == ADDR_CTRL1)) begin
        nest_dis_r <= bus_in.wdata[CTRL1_NEST_BIT];
      end
      if (bus_in.wr && (bus_in.addr == ADDR_CTRL2)) begin
        pol_r <= bus_in.wdata[NUM_EXT-1:0];
      end
    end
  end

  // Status word; sequencer updates override a same-cycle write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_r <= REG_RESET;
    end else begin
      if (stat_we) begin
        status_r <= (bus_in.wdata & STAT_PLAIN_MASK) |
                    (status_r & ~STAT_PLAIN_MASK);
        if (!nest_dis_r) begin
          status_r[STAT_IPL_LSB +: PRIO_W] <=
            bus_in.wdata[STAT_IPL_LSB +: PRIO_W];
        end
      end
      if (state_r == ST_VEC) begin
        // Without nesting every routine runs at level 7
        status_r[STAT_IPL_LSB +: PRIO_W] <=
          nest_dis_r ? PRIO_TOP : sel_prio_r;
      end
      if (state_r == ST_POP_HI) begin
        status_r[7:0] <= pop_ctx_in.status_low;
      end
    end
  end

  // Level top bit: software may only clear it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      core_msb_r <= 1'b0;
    end else if (state_r == ST_POP_HI) begin
      core_msb_r <= pop_ctx_in.prio_msb;
    end else if (core_we && !bus_in.wdata[CORE_MSB_BIT]) begin
      core_msb_r <= 1'b0;
    end
  end

  // Entry and return sequencer. The flag-set cycle is entry cycle 1,
  // so a two-cycle instruction finishes inside cycles 1 and 2.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      sel_prio_r <= PRIO_ZERO;
      sel_idx_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_entry) begin
            state_r <= ST_SAVE;
            sel_prio_r <= best_prio;
            sel_idx_r <= best_idx;
          end else if (start_ret) begin
            state_r <= ST_POP_HI;
          end
        end
        ST_SAVE: state_r <= ST_VEC;
        ST_VEC: state_r <= ST_LOAD;
        ST_LOAD: state_r <= ST_IDLE;
        ST_POP_HI: state_r <= ST_POP_LO;
        ST_POP_LO: state_r <= ST_REFETCH;
        ST_REFETCH: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Registered strobes to the core, one per sequence cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctx_save_out <= 1'b0;
      vec_fetch_out <= 1'b0;
      isr_load_out <= 1'b0;
      nop_exec_out <= 1'b0;
      pop_hi_out <= 1'b0;
      pop_lo_out <= 1'b0;
      ret_fetch_out <= 1'b0;
      ctx_out <= '0;
      vec_addr_out <= VEC_BASE;
    end else begin
      ctx_save_out <= start_entry;
      vec_fetch_out <= (state_r == ST_SAVE);
      isr_load_out <= (state_r == ST_VEC);
      nop_exec_out <= start_entry || (state_r == ST_VEC) ||
                      (state_r == ST_POP_LO);
      pop_hi_out <= start_ret;
      pop_lo_out <= (state_r == ST_POP_HI);
      ret_fetch_out <= (state_r == ST_POP_LO);
      if (start_entry) begin
        ctx_out.status_low <= status_r[7:0];
        ctx_out.prio_msb <= core_msb_r;
      end
      if (state_r == ST_SAVE) begin
        vec_addr_out <= VEC_BASE + VEC_STRIDE * VEC_W'(sel_idx_r);
      end
    end
  end

  // Wake, resume and request indications
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_out <= 1'b0;
      resume_out <= 1'b0;
      int_req_out <= 1'b0;
    end else begin
      wake_out <= any_wake;
      // Woken but not above level: continue after power-save
      resume_out <= sleep_in && any_wake && !req_hit;
      int_req_out <= req_hit;
    end
  end

  // Read multiplexer; unmapped indices read as zero
  always_comb begin
    rd_mux = REG_RESET;
    case (bus_in.addr)
      ADDR_FLAG: rd_mux = flags_r;
      ADDR_ENABLE: rd_mux = enable_r;
      ADDR_STATUS: rd_mux = status_r;
      ADDR_CORE: rd_mux[CORE_MSB_BIT] = core_msb_r;
      ADDR_CTRL1: rd_mux[CTRL1_NEST_BIT] = nest_dis_r;
      ADDR_CTRL2: rd_mux[NUM_EXT-1:0] = pol_r;
      default: begin
        if (bus_in.addr >= ADDR_PRIO0 && bus_in.addr <= ADDR_PRIO3) begin
          for (int j = 0; j < PRIO_PER_REG; j++) begin
            rd_mux[j*PRIO_STRIDE +: PRIO_W] =
              prio_r[(int'(bus_in.addr - ADDR_PRIO0) * PRIO_PER_REG) + j];
          end
        end
      end
    endcase
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= REG_RESET;
    end else begin
      rdata_out <= bus_in.rd ? rd_mux : REG_RESET;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_wake_follows: assert property (any_wake |=> wake_out)
    else $error("wake not raised for enabled flagged source");
  a_prio_zero_quiet: assert property (
    !any_wake |=> !wake_out && !int_req_out)
    else $error("wake or request without nonzero priority");
  a_entry_seq: assert property (
    start_entry |=> ctx_save_out ##1 vec_fetch_out ##1 isr_load_out
      ##1 (state_r == ST_IDLE))
    else $error("entry sequence not four cycles");
  // Level is written as the vector cycle ends, so it shows with the load
  a_ipl_raised: assert property (
    isr_load_out |-> (ipl_low == (nest_dis_r ? PRIO_TOP : sel_prio_r)))
    else $error("accepted priority not in level bits");
  a_req_above: assert property (
    start_entry |-> ({1'b0, best_prio} > cpu_level) &&
      (best_prio != PRIO_ZERO))
    else $error("entry at or below cpu level");
  a_resume_only: assert property (
    (sleep_in && any_wake && !req_hit) |=> resume_out && !ctx_save_out)
    else $error("resume missing or vectored");
  a_ret_seq: assert property (
    start_ret |=> pop_hi_out ##1 pop_lo_out ##1 (ret_fetch_out && !pop_lo_out))
    else $error("return sequence wrong");
  a_flag_sticky: assert property (
    !flag_we |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag cleared by hardware");
  a_adc_pin0: assert property (adc_trigger_out |-> flags_r[0])
    else $error("converter trigger without pin zero flag");
  a_ipl_locked: assert property (
    (stat_we && nest_dis_r && state_r != ST_VEC && state_r != ST_POP_HI)
      |=> $stable(ipl_low))
    else $error("level bits written while nesting disabled");
  a_msb_no_set: assert property (
    (core_we && !core_msb_r && state_r != ST_POP_HI) |=> !core_msb_r)
    else $error("software set level top bit");
  // Any tied pending source below the winner would break natural order
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_tie
      a_tie_low: assert property (
        (start_entry && wake_src[g] && prio_r[g] == best_prio)
          |=> sel_idx_r <= IDX_W'(g))
        else $error("tie not resolved to lowest vector");
    end
  endgenerate

  c_entry: cover property (start_entry ##4 (state_r == ST_IDLE));
  c_return: cover property (start_ret ##3 (state_r == ST_IDLE));
  c_resume: cover property (resume_out);
  c_adc: cover property (adc_trigger_out ##[1:8] ctx_save_out);
endmodule
`default_nettype wire

/* sim/vicwt_core_model.sv */
// Core-side model: stacks the saved context and returns it on a return
`timescale 1ns/1ps
`default_nettype none
module vicwt_core_model
  import vicwt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic isr_load_in,
  input wire vicwt_ctx_t ctx_in,
  input wire logic pop_hi_in,
  output vicwt_ctx_t pop_ctx_out
);
  vicwt_ctx_t stack_r;
  // Push the context as the routine starts
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stack_r <= '0;
    end else if (isr_load_in) begin
      stack_r <= ctx_in;
    end
  end
  // Junk outside the pop cycle, so a late sample shows up
  assign pop_ctx_out = pop_hi_in ? stack_r : ~stack_r;
endmodule
`default_nettype wire

/* sim/vicwt_ctrl_tb_top.sv */
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vicwt_ctrl_tb_top
  import vicwt_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  vicwt_bus_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_EXT-1:0] ext = '0;
  logic [NUM_PER-1:0] evt = '0;
  logic sleep = 1'b0;
  logic ret = 1'b0;
  vicwt_ctx_t pop_ctx, ctx;
  logic wake, resume, int_req, save, vfetch, load, nop;
  logic pop_hi, pop_lo, rfetch, adc;
  logic [VEC_W-1:0] vaddr;
  int error_cnt = 0;
  int samples_checked = 0;
  int adc_cnt = 0;

  always #10 clk_in = ~clk_in;

  vicwt_ctrl u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rdata), .ext_pin_in(ext), .periph_evt_in(evt),
    .sleep_in(sleep), .ret_instr_in(ret), .pop_ctx_in(pop_ctx),
    .wake_out(wake), .resume_out(resume), .int_req_out(int_req),
    .ctx_save_out(save), .ctx_out(ctx), .vec_fetch_out(vfetch),
    .vec_addr_out(vaddr), .isr_load_out(load), .nop_exec_out(nop),
    .pop_hi_out(pop_hi), .pop_lo_out(pop_lo), .ret_fetch_out(rfetch),
    .adc_trigger_out(adc));

  vicwt_core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .isr_load_in(load), .ctx_in(ctx), .pop_hi_in(pop_hi),
    .pop_ctx_out(pop_ctx));

  // Converter trigger pulses seen so far
  always @(posedge clk_in) begin
    if (adc === 1'b1) begin
      adc_cnt <= adc_cnt + 1;
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_in);
    bus <= '0;
    #1;
    chk("rdata", {16'h0000, e}, {16'h0000, rdata});
  endtask

  task automatic pulse_evt(input logic [10:0] m);
    @(posedge clk_in);
    evt <= m;
    @(posedge clk_in);
    evt <= '0;
  endtask

  // Cycles two to four of the entry
  task automatic entry_chk(input logic [23:0] va);
    cyc(1);
    chk("save_nop_req", 32'h7, {29'h0, save, nop, int_req});
    cyc(1);
    chk("vec", {8'h01, va}, {7'h0, vfetch, vaddr});
    cyc(1);
    chk("load_nop", 32'h3, {30'h0, load, nop});
  endtask

  task automatic ret_chk;
    @(posedge clk_in);
    ret <= 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
    #1;
    chk("pop_hi", 32'h1, {31'h0, pop_hi});
    cyc(1);
    chk("pop_lo", 32'h1, {31'h0, pop_lo});
    cyc(1);
    chk("refetch", 32'h3, {30'h0, rfetch, nop});
  endtask

  // Watchdog well past the expected run of about 110 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_FLAG, 16'h0000);
    rd(4'ha, 16'h0000);
    chk("vec_rst", 32'h14, {8'h00, vaddr});
    wr(ADDR_STATUS, 16'hffff);
    rd(ADDR_STATUS, 16'h01ef);
    wr(ADDR_CORE, 16'hffff);
    rd(ADDR_CORE, 16'h0000);
    // Level 7 blocks a level 7 source; sleep resumes instead
    wr(ADDR_ENABLE, 16'h00e0);
    wr(4'h3, 16'h0070);
    wr(ADDR_STATUS, 16'h00e0);
    sleep <= 1'b1;
    pulse_evt(11'h001);
    cyc(2);
    chk("wake_res_req", 32'h6, {29'h0, wake, resume, int_req});
    @(posedge clk_in);
    sleep <= 1'b0;
    wr(ADDR_FLAG, 16'h0000);
    // Plain entry at priority 3, then return
    wr(4'h3, 16'h0030);
    wr(ADDR_STATUS, 16'h0005);
    pulse_evt(11'h001);
    entry_chk(24'h00001e);
    rd(ADDR_STATUS, 16'h0065);
    rd(ADDR_FLAG, 16'h0020);
    wr(ADDR_FLAG, 16'h0000);
    ret_chk();
    rd(ADDR_STATUS, 16'h0005);
    // Equal priority tie, priority 0 neighbour, nesting disabled
    wr(4'h3, 16'h2200);
    wr(ADDR_CTRL1, 16'h8000);
    wr(ADDR_STATUS, 16'h00a5);
    rd(ADDR_STATUS, 16'h0005);
    pulse_evt(11'h007);
    entry_chk(24'h000020);
    rd(ADDR_STATUS, 16'h00e5);
    wr(ADDR_FLAG, 16'h0000);
    ret_chk();
    wr(ADDR_CTRL1, 16'h0000);
    // Priority 0 source stays silent even in sleep
    sleep <= 1'b1;
    pulse_evt(11'h001);
    cyc(3);
    chk("prio0", 32'h0, {29'h0, wake, resume, int_req});
    @(posedge clk_in);
    sleep <= 1'b0;
    wr(ADDR_FLAG, 16'h0000);
    // Pin edges, rising then falling polarity
    @(posedge clk_in);
    ext <= 5'h1f;
    cyc(6);
    rd(ADDR_FLAG, 16'h001f);
    chk("adc_rise", 32'h1, adc_cnt);
    wr(ADDR_CTRL2, 16'h001f);
    wr(ADDR_FLAG, 16'h0000);
    @(posedge clk_in);
    ext <= 5'h00;
    cyc(6);
    rd(ADDR_FLAG, 16'h001f);
    chk("adc_fall", 32'h2, adc_cnt);
    test_done();
  end
endmodule
`default_nettype wire
